// ==== src/deep_sleep_clock_gating.sv ====
// Deep-sleep clock gating control with its run and sleep companions.
// Assumes a classic Wishbone master and synchronous power requests.
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ns
module deep_sleep_clock_gating (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [31:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  output logic wbErr,
  // Power state requests
  input wire logic sleepReq,
  input wire logic deepReq,
  output logic [1:0] powerState,
  // Peripheral access check
  input wire logic perReq,
  input wire logic [3:0] perUnit,
  output logic perAck,
  output logic perFault,
  // Unit clock enables
  output logic ethPhyClkEn,
  output logic ethMacClkEn,
  output logic [7:0] portClkEn,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] runGate;
    logic [31:0] sleepGate;
    logic [31:0] deepGate;
    logic autoGate;
    logic [dsgate_pkg::IRQ_BITS-1:0] irqStat;
    logic [dsgate_pkg::IRQ_BITS-1:0] irqEn;
    dsgate_pkg::pwr_state_t pwr;
    logic ack;
    logic err;
    logic [31:0] datO;
    logic irq;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;

  gate_if gates ();

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  gate_select u_select (
    .clk(clk),
    .rst(rst),
    .autoGate(st_ff.autoGate),
    .pwrState(st_ff.pwr),
    .runGate(st_ff.runGate),
    .sleepGate(st_ff.sleepGate),
    .deepGate(st_ff.deepGate),
    .gates(gates.drive)
  );

  fault_check u_check (
    .clk(clk),
    .rst(rst),
    .gates(gates.sink),
    .perReq(perReq),
    .perUnit(perUnit),
    .perAck(perAck),
    .perFault(perFault)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic req;
  logic inBase;
  logic aligned;
  logic [11:0] ofs;
  logic hit;
  logic wr;
  logic [31:0] byteMask;
  logic [dsgate_pkg::IRQ_BITS-1:0] events;
  logic [dsgate_pkg::IRQ_BITS-1:0] clrBits;
  logic [31:0] rdVal;
  logic [31:0] cfgNew;
  dsgate_pkg::pwr_state_t pwrNext;

  // Byte lanes of a Wishbone write
  function automatic logic [31:0] lanes(input logic [3:0] sel);
    lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Merge a write into a register, keeping read-only bits at zero
  function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [31:0] bm,
                                         input logic [31:0] wmask);
    merge = ((old & ~bm) | (dat & bm)) & wmask;
  endfunction

  always_comb begin
    req = wbCyc && wbStb && !st_ff.ack && !st_ff.err;
    inBase = wbAdr[31:dsgate_pkg::BASE_LSB]
      == dsgate_pkg::SYSCTL_BASE[31:dsgate_pkg::BASE_LSB];
    aligned = wbAdr[1:0] == 2'h0;
    ofs = wbAdr[dsgate_pkg::BASE_LSB-1:0];
    wr = req && wbWe;
    byteMask = lanes(wbSel);
    hit = 1'b0;
    rdVal = 32'h00000000;
    if (inBase && aligned) begin
      case (ofs)
        dsgate_pkg::RUN_CFG_OFS: begin
          hit = 1'b1;
          rdVal[dsgate_pkg::ACG_BIT] = st_ff.autoGate;
        end
        dsgate_pkg::RUN_GATE_OFS: begin
          hit = 1'b1;
          rdVal = st_ff.runGate;
        end
        dsgate_pkg::SLEEP_GATE_OFS: begin
          hit = 1'b1;
          rdVal = st_ff.sleepGate;
        end
        dsgate_pkg::DEEP_GATE_OFS: begin
          hit = 1'b1;
          rdVal = st_ff.deepGate & dsgate_pkg::GATE_WMASK;
        end
        dsgate_pkg::IRQ_STAT_OFS: begin
          hit = 1'b1;
          rdVal[dsgate_pkg::IRQ_BITS-1:0] = st_ff.irqStat;
        end
        dsgate_pkg::IRQ_EN_OFS: begin
          hit = 1'b1;
          rdVal[dsgate_pkg::IRQ_BITS-1:0] = st_ff.irqEn;
        end
        dsgate_pkg::IRQ_CLR_OFS: begin
          hit = 1'b1;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  always_comb begin
    case ({deepReq, sleepReq})
      2'b00: pwrNext = dsgate_pkg::PWR_RUN;
      2'b01: pwrNext = dsgate_pkg::PWR_SLEEP;
      default: pwrNext = dsgate_pkg::PWR_DEEP;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pwr = pwrNext;
    nxt_st.ack = req && hit;
    nxt_st.err = req && !hit;
    nxt_st.datO = (req && hit && !wbWe) ? rdVal : 32'h00000000;
    clrBits = '0;
    cfgNew = 32'h00000000;
    if (wr && hit) begin
      case (ofs)
        dsgate_pkg::RUN_CFG_OFS: begin
          cfgNew = merge(32'(st_ff.autoGate) << dsgate_pkg::ACG_BIT,
                         wbDatI, byteMask, dsgate_pkg::CFG_WMASK);
          nxt_st.autoGate = cfgNew[dsgate_pkg::ACG_BIT];
        end
        dsgate_pkg::RUN_GATE_OFS: begin
          nxt_st.runGate = merge(st_ff.runGate, wbDatI, byteMask,
                                 dsgate_pkg::GATE_WMASK);
        end
        dsgate_pkg::SLEEP_GATE_OFS: begin
          nxt_st.sleepGate = merge(st_ff.sleepGate, wbDatI, byteMask,
                                   dsgate_pkg::GATE_WMASK);
        end
        dsgate_pkg::DEEP_GATE_OFS: begin
          nxt_st.deepGate = merge(st_ff.deepGate, wbDatI, byteMask,
                                  dsgate_pkg::GATE_WMASK);
        end
        dsgate_pkg::IRQ_EN_OFS: begin
          nxt_st.irqEn = (st_ff.irqEn & ~byteMask[dsgate_pkg::IRQ_BITS-1:0])
                         | (wbDatI[dsgate_pkg::IRQ_BITS-1:0]
                            & byteMask[dsgate_pkg::IRQ_BITS-1:0]);
        end
        dsgate_pkg::IRQ_CLR_OFS: begin
          clrBits = wbDatI[dsgate_pkg::IRQ_BITS-1:0]
                    & byteMask[dsgate_pkg::IRQ_BITS-1:0];
        end
        default: begin
          clrBits = '0;
        end
      endcase
    end
    // Faults, deep-sleep entry and wake-up
    events = '0;
    events[dsgate_pkg::IRQ_FAULT] = perFault;
    events[dsgate_pkg::IRQ_DEEP] = pwrNext == dsgate_pkg::PWR_DEEP
                                   && st_ff.pwr != dsgate_pkg::PWR_DEEP;
    events[dsgate_pkg::IRQ_WAKE] = pwrNext == dsgate_pkg::PWR_RUN
                                   && st_ff.pwr != dsgate_pkg::PWR_RUN;
    // Set wins over a clear in the same cycle
    nxt_st.irqStat = (st_ff.irqStat & ~clrBits) | events;
    nxt_st.irq = |(nxt_st.irqStat & nxt_st.irqEn);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff.runGate <= dsgate_pkg::GATE_RESET;
      st_ff.sleepGate <= dsgate_pkg::GATE_RESET;
      st_ff.deepGate <= dsgate_pkg::GATE_RESET;
      st_ff.autoGate <= dsgate_pkg::CFG_RESET[dsgate_pkg::ACG_BIT];
      st_ff.irqStat <= dsgate_pkg::IRQ_RESET;
      st_ff.irqEn <= dsgate_pkg::IRQ_RESET;
      st_ff.pwr <= dsgate_pkg::PWR_RUN;
      st_ff.ack <= 1'b0;
      st_ff.err <= 1'b0;
      st_ff.datO <= 32'h00000000;
      st_ff.irq <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wbDatO = st_ff.datO;
  assign wbAck = st_ff.ack;
  assign wbErr = st_ff.err;
  assign powerState = st_ff.pwr;
  assign irq = st_ff.irq;
  assign ethPhyClkEn = gates.unitOn[dsgate_pkg::PHY_UNIT];
  assign ethMacClkEn = gates.unitOn[dsgate_pkg::MAC_UNIT];
  assign portClkEn = gates.unitOn[7:0];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence deep_write;
    wbCyc && wbStb && wbWe && !wbAck && !wbErr
      && wbAdr == (dsgate_pkg::SYSCTL_BASE
                   | {20'h0, dsgate_pkg::DEEP_GATE_OFS});
  endsequence

  sequence deep_read;
    wbCyc && wbStb && !wbWe && !wbAck && !wbErr
      && wbAdr == (dsgate_pkg::SYSCTL_BASE
                   | {20'h0, dsgate_pkg::DEEP_GATE_OFS});
  endsequence

  deep_reset_a: assert property (@(posedge clk)
    $fell(rst) |-> st_ff.deepGate == dsgate_pkg::GATE_RESET
      && gates.unitOn == '0)
    else $error("deep-sleep gates not cleared by reset");

  reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
    deep_read |=> wbAck && !wbErr
      && (wbDatO & ~dsgate_pkg::GATE_WMASK) == 32'h00000000
      ##1 !wbAck)
    else $error("reserved deep-sleep bits read non-zero");

  phy_bit_a: assert property (@(posedge clk) disable iff (rst)
    (deep_write and wbSel[3])
      |=> st_ff.deepGate[dsgate_pkg::PHY_BIT]
          == $past(wbDatI[dsgate_pkg::PHY_BIT]))
    else $error("PHY gate bit not written");

  mac_bit_a: assert property (@(posedge clk) disable iff (rst)
    (deep_write and wbSel[3])
      |=> st_ff.deepGate[dsgate_pkg::MAC_BIT]
          == $past(wbDatI[dsgate_pkg::MAC_BIT]) ##2
          ethMacClkEn == ($past(st_ff.autoGate)
            && $past(st_ff.pwr) == dsgate_pkg::PWR_DEEP
            ? $past(st_ff.deepGate[dsgate_pkg::MAC_BIT]) : ethMacClkEn))
    else $error("MAC gate bit not written or applied");

  port_bits_a: assert property (@(posedge clk) disable iff (rst)
    (deep_write and wbSel[0])
      |=> st_ff.deepGate[7:0] == $past(wbDatI[7:0]))
    else $error("port gate bits not written");

  unmapped_err_a: assert property (@(posedge clk) disable iff (rst)
    wbCyc && wbStb && !wbAck && !wbErr
      && wbAdr[31:dsgate_pkg::BASE_LSB]
         != dsgate_pkg::SYSCTL_BASE[31:dsgate_pkg::BASE_LSB]
      |=> wbErr && !wbAck)
    else $error("access outside base not refused");

  // ----------------------------------------------------------------
  // Bus, status and unit enable checks
  // ----------------------------------------------------------------
  sequence bus_taken;
    wbCyc && wbStb && !wbAck && !wbErr;
  endsequence

  misaligned_err_a: assert property (@(posedge clk) disable iff (rst)
    (bus_taken and wbAdr[1:0] != 2'h0) |=> wbErr && !wbAck)
    else $error("misaligned access not refused");

  err_keeps_a: assert property (@(posedge clk) disable iff (rst)
    (bus_taken and !hit) |=> $stable(st_ff.deepGate))
    else $error("refused access changed the deep-sleep gates");

  ack_pulse_a: assert property (@(posedge clk) disable iff (rst)
    bus_taken ##1 wbAck |=> !wbAck && !wbErr)
    else $error("acknowledge held beyond one cycle");

  reserved_write_a: assert property (@(posedge clk) disable iff (rst)
    deep_write
      |=> (st_ff.deepGate & ~dsgate_pkg::GATE_WMASK) == 32'h00000000)
    else $error("reserved deep-sleep bits took a write");

  fault_status_a: assert property (@(posedge clk) disable iff (rst)
    perFault |=> st_ff.irqStat[dsgate_pkg::IRQ_FAULT])
    else $error("bus fault not recorded in status");

  deep_state_a: assert property (@(posedge clk) disable iff (rst)
    deepReq |=> powerState == dsgate_pkg::PWR_DEEP)
    else $error("deep-sleep request did not select deep sleep");

  port_map_a: assert property (@(posedge clk) disable iff (rst)
    !st_ff.autoGate
      |=> {ethPhyClkEn, ethMacClkEn, portClkEn}
          == {$past(st_ff.runGate[dsgate_pkg::PHY_BIT]),
              $past(st_ff.runGate[dsgate_pkg::MAC_BIT]),
              $past(st_ff.runGate[7:0])})
    else $error("unit enables not in register bit order");

endmodule

// ==== shared/dsgate_pkg.sv ====
// Constants and types for the deep-sleep clock gating control block.
// Assumes a 32-bit classic Wishbone slave at the system control base.
//
// Notes on behaviour
// - A set gate bit clocks its unit; a clear bit stops and disables it.
// - Access to a unit whose clock is off is answered with a bus fault.
// - The deep-sleep gate register resets to all zeros, every unit unclocked.
// - Run, sleep and deep-sleep gate registers apply in their own state.
// - Sleep and deep-sleep registers apply only while auto gating is set.
// - Bit 30, read/write, gates the Ethernet PHY clock in deep sleep.
// - Bit 28, read/write, gates the Ethernet MAC clock in deep sleep.
// - Bits 7 to 0, read/write, gate ports H down to A.
// - Bits 31, 29 and 27:8 are read-only zero; software preserves them.
// - The register decodes at offset 0x128 from base 0x400fe000.
package dsgate_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [31:0] SYSCTL_BASE = 32'h400fe000;
  localparam int BASE_LSB = 12;
  localparam logic [11:0] RUN_CFG_OFS = 12'h060;
  localparam logic [11:0] RUN_GATE_OFS = 12'h108;
  localparam logic [11:0] SLEEP_GATE_OFS = 12'h118;
  localparam logic [11:0] DEEP_GATE_OFS = 12'h128;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h200;
  localparam logic [11:0] IRQ_EN_OFS = 12'h204;
  localparam logic [11:0] IRQ_CLR_OFS = 12'h208;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int ACG_BIT = 27;
  localparam int PHY_BIT = 30;
  localparam int MAC_BIT = 28;
  localparam int PORT_MSB = 7;
  localparam int PORT_LSB = 0;
  localparam logic [31:0] GATE_RESET = 32'h00000000;
  localparam logic [31:0] GATE_WMASK = 32'h500000ff;
  localparam logic [31:0] CFG_RESET = 32'h00000000;
  localparam logic [31:0] CFG_WMASK = 32'h08000000;
  localparam int UNITS = 10;
  localparam int MAC_UNIT = 8;
  localparam int PHY_UNIT = 9;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_DEEP = 1;
  localparam int IRQ_WAKE = 2;
  localparam int IRQ_BITS = 3;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_DEEP} pwr_state_t;

  // Register layout to unit order: ports A..H, then MAC, then PHY
  function automatic logic [UNITS-1:0] to_units(input logic [31:0] g);
    to_units = {g[PHY_BIT], g[MAC_BIT], g[PORT_MSB:PORT_LSB]};
  endfunction

endpackage

// ==== shared/gate_if.sv ====
// Selected per-unit clock gates shared between the gating modules.
// Assumes one driver (gate selector) and any number of readers.
`timescale 1ns/1ns
interface gate_if;
  logic [dsgate_pkg::UNITS-1:0] unitOn;
  modport drive (output unitOn);
  modport sink (input unitOn);
endinterface

// ==== src/gate_select.sv ====
// Chooses the gate register that applies in the current power state.
// Assumes the power state and registers are synchronous to clk.
`timescale 1ns/1ns
module gate_select (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Gate sources
  input wire logic autoGate,
  input wire dsgate_pkg::pwr_state_t pwrState,
  input wire logic [31:0] runGate,
  input wire logic [31:0] sleepGate,
  input wire logic [31:0] deepGate,
  // Selected gates
  gate_if.drive gates
);

  typedef struct packed {
    logic [dsgate_pkg::UNITS-1:0] unitOn;
  } sel_state_t;

  sel_state_t st_ff;
  sel_state_t nxt_st;
  logic [31:0] chosen;

  always_comb begin
    chosen = runGate;
    if (autoGate) begin
      case (pwrState)
        dsgate_pkg::PWR_RUN: chosen = runGate;
        dsgate_pkg::PWR_SLEEP: chosen = sleepGate;
        dsgate_pkg::PWR_DEEP: chosen = deepGate;
        default: chosen = runGate;
      endcase
    end
    nxt_st = st_ff;
    nxt_st.unitOn = dsgate_pkg::to_units(chosen);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign gates.unitOn = st_ff.unitOn;

  acg_off_a: assert property (@(posedge clk) disable iff (rst)
    !autoGate |=> gates.unitOn == dsgate_pkg::to_units($past(runGate)))
    else $error("run gates not applied with auto gating clear");

  deep_apply_a: assert property (@(posedge clk) disable iff (rst)
    autoGate && pwrState == dsgate_pkg::PWR_DEEP
      |=> gates.unitOn == dsgate_pkg::to_units($past(deepGate)))
    else $error("deep-sleep gates not applied in deep sleep");

endmodule

// ==== src/fault_check.sv ====
// Answers peripheral accesses: grant if the unit is clocked, else fault.
// Assumes perReq is a one-cycle request with a unit index beside it.
`timescale 1ns/1ns
module fault_check (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Selected gates
  gate_if.sink gates,
  // Peripheral access
  input wire logic perReq,
  input wire logic [3:0] perUnit,
  output logic perAck,
  output logic perFault
);

  typedef struct packed {
    logic ack;
    logic fault;
  } chk_state_t;

  chk_state_t st_ff;
  chk_state_t nxt_st;
  logic clocked;

  always_comb begin
    clocked = 1'b0;
    if (perUnit < 4'(dsgate_pkg::UNITS)) begin
      clocked = gates.unitOn[perUnit];
    end
    nxt_st.ack = perReq && clocked;
    nxt_st.fault = perReq && !clocked;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign perAck = st_ff.ack;
  assign perFault = st_ff.fault;

  gated_fault_a: assert property (@(posedge clk) disable iff (rst)
    perReq && !clocked |=> perFault && !perAck)
    else $error("access to unclocked unit not faulted");

  clocked_grant_a: assert property (@(posedge clk) disable iff (rst)
    perReq && clocked |=> perAck && !perFault
      ##1 (!perFault || $past(perReq)))
    else $error("access to clocked unit not granted");

endmodule

// ==== verif/unit_access_model.sv ====
// Model of the bus side that reaches the gated units.
// Assumes the block answers one cycle after the edge that takes a request.
`timescale 1ns/1ns
module unit_access_model (
  // Clock
  input wire logic clk,
  // Access toward the gating block
  output logic perReq,
  output logic [3:0] perUnit,
  input wire logic perAck,
  input wire logic perFault
);
  logic gotAck;
  logic gotFault;
  initial begin
    perReq = 1'b0;
    perUnit = 4'h0;
  end
  // ----------------------------------------
  // One access, answer taken one cycle later
  // ----------------------------------------
  task automatic access(input logic [3:0] unit);
    @(posedge clk);
    perReq <= 1'b1;
    perUnit <= unit;
    @(posedge clk);
    perReq <= 1'b0;
    perUnit <= ~unit;
    @(posedge clk);
    gotAck = perAck;
    gotFault = perFault;
  endtask
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the deep-sleep clock gating block.
// Assumes a one-cycle Wishbone answer and enables two cycles after a cause.
`timescale 1ns/1ns
module tb_top;
  logic clk, rst, wbCyc, wbStb, wbWe, sleepReq, deepReq;
  logic wbAck, wbErr, perReq, perAck, perFault, ethPhyClkEn, ethMacClkEn, irq;
  logic [31:0] wbAdr, wbDatI, wbDatO, rd, g;
  logic [3:0] wbSel, perUnit;
  logic [1:0] powerState;
  logic [7:0] portClkEn;
  logic er;
  logic [31:0] regs[int];
  int num_errors, n_compared, cycles;
  initial clk = 1'b0;
  always #10 clk = ~clk;
  deep_sleep_clock_gating i_dut(.clk(clk), .rst(rst), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .wbErr(wbErr),
    .sleepReq(sleepReq), .deepReq(deepReq), .powerState(powerState),
    .perReq(perReq), .perUnit(perUnit), .perAck(perAck),
    .perFault(perFault), .ethPhyClkEn(ethPhyClkEn),
    .ethMacClkEn(ethMacClkEn), .portClkEn(portClkEn), .irq(irq));
  unit_access_model i_unit(.clk(clk), .perReq(perReq), .perUnit(perUnit),
    .perAck(perAck), .perFault(perFault));
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // Bus cycles and register model
  // ----------------------------------------
  task automatic wb(input logic we, input logic [31:0] adr,
                    input logic [31:0] dat, input logic [3:0] sel);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= sel;
    wbDatI <= dat;
    do @(posedge clk); while (wbAck !== 1'b1 && wbErr !== 1'b1);
    rd = wbDatO;
    er = wbErr;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask
  function automatic logic [31:0] wmask(input logic [11:0] ofs);
    case (ofs)
      dsgate_pkg::RUN_CFG_OFS: return 32'h08000000;
      dsgate_pkg::IRQ_EN_OFS: return 32'h00000007;
      dsgate_pkg::RUN_GATE_OFS, dsgate_pkg::SLEEP_GATE_OFS,
      dsgate_pkg::DEEP_GATE_OFS: return 32'h500000ff;
      default: return 32'h00000000;
    endcase
  endfunction
  task automatic wr(input logic [11:0] ofs, input logic [31:0] dat,
                    input logic [3:0] sel);
    logic [31:0] m;
    m = wmask(ofs) & {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    wb(1'b1, dsgate_pkg::SYSCTL_BASE | ofs, dat, sel);
    regs[ofs] = (regs[ofs] & ~m) | (dat & m);
    check("write err", er, 1'b0);
  endtask
  task automatic rdchk(input logic [11:0] ofs);
    wb(1'b0, dsgate_pkg::SYSCTL_BASE | ofs, 32'h00000000, 4'hf);
    check("readback", rd, regs[ofs]);
  endtask
  // ----------------------------------------
  // Expected gating per power state
  // ----------------------------------------
  task automatic setpwr(input logic s, input logic d);
    logic [1:0] p;
    logic e;
    p = d ? 2'h2 : (s ? 2'h1 : 2'h0);
    @(posedge clk);
    sleepReq <= s;
    deepReq <= d;
    repeat (3) @(posedge clk);
    check("state", powerState, p);
    g = regs[dsgate_pkg::RUN_GATE_OFS];
    if (regs[dsgate_pkg::RUN_CFG_OFS][27] && p == 2'h1)
      g = regs[dsgate_pkg::SLEEP_GATE_OFS];
    if (regs[dsgate_pkg::RUN_CFG_OFS][27] && p == 2'h2)
      g = regs[dsgate_pkg::DEEP_GATE_OFS];
    check("enables", {ethPhyClkEn, ethMacClkEn, portClkEn},
          {g[30], g[28], g[7:0]});
    for (int u = 0; u < 11; u++) begin
      e = u < 8 ? g[u] : (u == 8 ? g[28] : (u == 9 ? g[30] : 1'b0));
      i_unit.access(u[3:0]);
      check("grant", i_unit.gotAck, e);
      check("fault", i_unit.gotFault, !e);
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {wbCyc, wbStb, wbWe, sleepReq, deepReq} = 5'h00;
    wbAdr = 32'h00000000;
    wbDatI = 32'h00000000;
    wbSel = 4'h0;
    void'($urandom(20648));
    regs.delete();
    regs[dsgate_pkg::RUN_CFG_OFS] = 32'h00000000;
    regs[dsgate_pkg::RUN_GATE_OFS] = 32'h00000000;
    regs[dsgate_pkg::SLEEP_GATE_OFS] = 32'h00000000;
    regs[dsgate_pkg::DEEP_GATE_OFS] = 32'h00000000;
    regs[dsgate_pkg::IRQ_STAT_OFS] = 32'h00000000;
    regs[dsgate_pkg::IRQ_EN_OFS] = 32'h00000000;
    regs[dsgate_pkg::IRQ_CLR_OFS] = 32'h00000000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    check("reset enables", {ethPhyClkEn, ethMacClkEn, portClkEn}, 0);
    foreach (regs[k]) rdchk(k[11:0]);
    wr(dsgate_pkg::DEEP_GATE_OFS, 32'hffffffff, 4'hf);
    rdchk(dsgate_pkg::DEEP_GATE_OFS);
    wr(dsgate_pkg::DEEP_GATE_OFS, $urandom, 4'($urandom));
    rdchk(dsgate_pkg::DEEP_GATE_OFS);
    // Read-modify-write keeps reserved bits, enables port A
    wb(1'b0, dsgate_pkg::SYSCTL_BASE | dsgate_pkg::DEEP_GATE_OFS, 0, 4'hf);
    wr(dsgate_pkg::DEEP_GATE_OFS, rd | 32'h00000001, 4'hf);
    rdchk(dsgate_pkg::DEEP_GATE_OFS);
    wb(1'b1, 32'h400fe12c, 32'hffffffff, 4'hf);
    check("unmapped", er, 1'b1);
    wb(1'b1, 32'h400fe129, 32'hffffffff, 4'hf);
    check("misaligned", er, 1'b1);
    wb(1'b1, 32'h400ff128, 32'hffffffff, 4'hf);
    check("outside base", er, 1'b1);
    rdchk(dsgate_pkg::DEEP_GATE_OFS);
    for (int a = 0; a < 2; a++) begin
      wr(dsgate_pkg::RUN_CFG_OFS, a ? 32'hffffffff : 32'h0, 4'hf);
      wr(dsgate_pkg::RUN_GATE_OFS, $urandom, 4'hf);
      wr(dsgate_pkg::SLEEP_GATE_OFS, $urandom, 4'hf);
      wr(dsgate_pkg::DEEP_GATE_OFS, $urandom, 4'hf);
      for (int p = 0; p < 5; p++)
        setpwr(p[0], p[1]);
    end
    // Interrupt raised, masked and cleared
    wr(dsgate_pkg::IRQ_CLR_OFS, 32'h00000007, 4'hf);
    wr(dsgate_pkg::IRQ_EN_OFS, 32'h00000001, 4'hf);
    i_unit.access(4'ha);
    repeat (2) @(posedge clk);
    check("irq raised", irq, 1'b1);
    wb(1'b0, dsgate_pkg::SYSCTL_BASE | dsgate_pkg::IRQ_STAT_OFS, 0, 4'hf);
    check("fault status", rd[0], 1'b1);
    wr(dsgate_pkg::IRQ_EN_OFS, 32'h00000000, 4'hf);
    repeat (2) @(posedge clk);
    check("irq masked", irq, 1'b0);
    wr(dsgate_pkg::IRQ_EN_OFS, 32'h00000001, 4'hf);
    wr(dsgate_pkg::IRQ_CLR_OFS, 32'h00000007, 4'hf);
    repeat (2) @(posedge clk);
    check("irq cleared", irq, 1'b0);
    wrap_up();
  end
endmodule
